// ### src/mise_pkg.sv
// package: opcodes, carriers and constants of the instruction subset execution unit
//
// Overview of operation
// - complement-to-w writes inverted byte, sets zero
// - bcd adjust adds 6 to low nibble
// - bcd adjust adds 6 to high nibble
// - adjust adds 00H/06H/60H/66H, result to memory
// - bcd adjust touches only the carry flag
// - memory minus one writes back, updates zero
// - minus-one-to-w loads w, memory untouched, zero
// - power down halts execution, stops clock
// - power down clears watchdog counter and prescaler
// - power down sets pd flag, clears timeout
// - memory plus one writes back, updates zero
// - plus-one-to-w loads w, memory untouched, zero
// - jump loads program counter from instruction
// - jump takes two instruction cycles
package mise_pkg;

    localparam int DATA_W = 8;          // data memory and working register width
    localparam int ADDR_W = 8;          // data memory address width
    localparam int PC_W = 12;           // default program counter width

    localparam logic [3:0] NIBBLE_MAX = 4'h9;     // largest legal bcd digit
    localparam logic [7:0] ADJ_NONE = 8'h00;      // no decimal correction
    localparam logic [7:0] ADJ_LOW = 8'h06;       // low digit correction
    localparam logic [7:0] ADJ_HIGH = 8'h60;      // high digit correction
    localparam logic [7:0] ADJ_BOTH = 8'h66;      // both digits corrected
    localparam logic [7:0] BYTE_ONE = 8'h01;      // step of plus/minus one
    localparam logic [7:0] BYTE_ZERO = 8'h00;     // zero byte
    localparam int JUMP_CYCLES = 2;               // instruction cycles of an absolute jump

    // instructions handled by this unit
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_COMPLEMENT_TO_W = 4'h1,
        OP_BCD_ADJUST = 4'h2,
        OP_MEMORY_MINUS_ONE = 4'h3,
        OP_MEMORY_MINUS_ONE_TO_W = 4'h4,
        OP_POWER_DOWN = 4'h5,
        OP_MEMORY_PLUS_ONE = 4'h6,
        OP_MEMORY_PLUS_ONE_TO_W = 4'h7,
        OP_JUMP_ABSOLUTE = 4'h8
    } mise_op_t;

    // sequencer states, gray coded: run is one bit away from flush and from sleep
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_JUMP_FLUSH = 2'b01,
        ST_SLEEP = 2'b10
    } mise_state_e_t;

    // one issued instruction with its fetched operand
    typedef struct packed {
        logic valid;
        mise_op_t op;
        logic [ADDR_W-1:0] memAddr;
        logic [DATA_W-1:0] memData;
        logic [PC_W-1:0] target;
    } mise_instr_t;

    // status flags kept by the unit
    typedef struct packed {
        logic zero;
        logic carry;
        logic halfCarry;
        logic powerDown;
        logic watchdogTimeout;
    } mise_flags_t;

    // data memory write request
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mise_memwr_t;

    // datapath answer for one instruction
    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic writeW;
        logic writeMem;
        logic writeZero;
        logic writeCarry;
        logic carry;
    } mise_alu_t;

    // zero test shared by every zero-flag update
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == BYTE_ZERO;
    endfunction

endpackage

// ### src/mise_alu.sv
// datapath of the instruction subset: complement, bcd adjust, plus and minus one
module mise_alu (
    // operation and operands
    input wire mise_pkg::mise_op_t op,
    input wire logic [mise_pkg::DATA_W-1:0] memData,
    input wire logic [mise_pkg::DATA_W-1:0] wreg,
    input wire logic carryIn,
    input wire logic halfCarryIn,
    // result
    output mise_pkg::mise_alu_t res
);
    import mise_pkg::*;

    logic lowFix;                  // low digit needs correction
    logic highFix;                 // high digit needs correction
    logic [7:0] adjust;            // one of the four correction constants
    logic [DATA_W:0] adjSum;       // corrected value with carry out

    // decimal correction picks a constant from digit and flag tests
    always_comb begin
        lowFix = (wreg[3:0] > NIBBLE_MAX) || halfCarryIn;
        highFix = (wreg[7:4] > NIBBLE_MAX) || carryIn;
        unique case ({highFix, lowFix})
            2'b00: adjust = ADJ_NONE;
            2'b01: adjust = ADJ_LOW;
            2'b10: adjust = ADJ_HIGH;
            2'b11: adjust = ADJ_BOTH;
        endcase
        adjSum = {1'b0, wreg} + {1'b0, adjust};
    end

    // per-opcode result and which destinations take it
    always_comb begin
        res = '0;
        unique case (op)
            OP_COMPLEMENT_TO_W: begin
                res.value = ~memData;
                res.writeW = 1'b1;
                res.writeZero = 1'b1;
            end
            OP_BCD_ADJUST: begin
                res.value = adjSum[DATA_W-1:0];
                res.writeMem = 1'b1;
                res.writeCarry = 1'b1;
                // carry stays set if already set, or the correction overflowed
                res.carry = carryIn | adjSum[DATA_W];
            end
            OP_MEMORY_MINUS_ONE: begin
                res.value = memData - BYTE_ONE;
                res.writeMem = 1'b1;
                res.writeZero = 1'b1;
            end
            OP_MEMORY_MINUS_ONE_TO_W: begin
                res.value = memData - BYTE_ONE;
                res.writeW = 1'b1;
                res.writeZero = 1'b1;
            end
            OP_MEMORY_PLUS_ONE: begin
                res.value = memData + BYTE_ONE;
                res.writeMem = 1'b1;
                res.writeZero = 1'b1;
            end
            OP_MEMORY_PLUS_ONE_TO_W: begin
                res.value = memData + BYTE_ONE;
                res.writeW = 1'b1;
                res.writeZero = 1'b1;
            end
            // jump, power down and nop leave the datapath idle
            default: res = '0;
        endcase
    end

endmodule

// ### src/mise_exec.sv
// execution unit for complement, bcd adjust, plus/minus one, power down and jump
module mise_exec #(
    parameter int PC_WIDTH = mise_pkg::PC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // instruction issue
    input wire mise_pkg::mise_instr_t instr,
    output logic ready,
    // flag side inputs from the rest of the core
    input wire logic flagLoad,
    input wire mise_pkg::mise_flags_t flagLoadValue,
    input wire logic watchdogTimeoutEvent,
    // wake pin, asynchronous
    input wire logic wakePin,
    // architectural state
    output logic [mise_pkg::DATA_W-1:0] workingRegister,
    output mise_pkg::mise_flags_t flags,
    output logic [PC_WIDTH-1:0] programCounter,
    // data memory write port
    output mise_pkg::mise_memwr_t memWrite,
    // power control
    output logic watchdogClear,
    output logic systemClockEnable,
    output logic halted
);
    import mise_pkg::*;

    // the unit executes one instruction per open issue slot: the operand is
    // fetched by the core and arrives together with the instruction, and the
    // result is written back at the next edge. a jump closes the slot for one
    // dummy cycle; power down closes it until the wake pin is seen. the data
    // memory itself lives outside, so the to-w forms simply raise no strobe.
    // limitation: there is no stall input, the core must honour ready itself.

    // registered state of the unit apart from the two synchronisers; every output of the module
    // is one field of it, so nothing at the boundary is decoded logic
    typedef struct packed {
        mise_state_e_t fsm;        // sequencer state
        logic [PC_WIDTH-1:0] pc;   // address of the next instruction
        logic [DATA_W-1:0] wreg;   // working register
        mise_flags_t flags;        // status flags
        mise_memwr_t mem;          // pending data memory write
        logic wdtClear;            // watchdog and prescaler clear pulse
        logic clkEn;               // system clock gate control
        logic ready;               // issue slot open
        logic halt;                // sleeping; kept apart from fsm so the pin is a flop
    } mise_core_t;

    // program counter constants
    localparam logic [PC_WIDTH-1:0] PC_STEP = PC_WIDTH'(1); // sequential fetch step
    localparam logic [PC_WIDTH-1:0] PC_RESET = '0;           // reset vector

    // internal signals
    logic [1:0] rstPipe;       // reset release synchroniser
    logic rstSyncN;            // synchronised active-low reset
    logic [1:0] wakePipe;      // wake pin synchroniser
    logic wakeSync;            // wake level, safe to use
    mise_core_t state_reg;     // registered state
    mise_core_t state_next;    // next state
    mise_alu_t alu;            // datapath answer
    logic issue;               // an instruction is taken this cycle

    // reset is asserted at once but released only after two clean edges;
    // a release that lands close to a clock edge could otherwise leave part
    // of the state in reset and part of it running for one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // the wake pin is unrelated to clk, so it passes two flops first;
    // a wake pulse shorter than one clock may be missed, so the source
    // must hold the pin until the unit reports that it runs again
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wakePipe <= 2'b00;
        end else begin
            wakePipe <= {wakePipe[0], wakePin};
        end
    end
    assign wakeSync = wakePipe[1];

    // shared datapath; it sees the fetched operand directly and the
    // registered working register and flags, so results land one edge later
    mise_alu u_alu (
        .op(instr.op),
        .memData(instr.memData),
        .wreg(state_reg.wreg),
        .carryIn(state_reg.flags.carry),
        .halfCarryIn(state_reg.flags.halfCarry),
        .res(alu)
    );

    // an instruction offered while the slot is closed is ignored, not queued
    assign issue = instr.valid && state_reg.ready;

    // next-state logic: sequencer, datapath write-back and flag updates
    // priority, lowest first: hold, flag load from the core, the issued
    // instruction's own flag writes, and last the watchdog timeout event
    always_comb begin
        state_next = state_reg;
        state_next.mem.we = 1'b0;      // write strobe is a one-cycle pulse
        state_next.wdtClear = 1'b0;    // watchdog clear is a one-cycle pulse

        // flags loaded by other instructions of the core; a load in the same
        // cycle as an instruction that writes the same flag loses to it
        if (flagLoad) begin
            state_next.flags = flagLoadValue;
        end

        unique case (state_reg.fsm)
            ST_RUN: begin
                if (issue) begin
                    // sequential instructions step the counter; a jump overrides below
                    state_next.pc = state_reg.pc + PC_STEP;
                    // complement and the to-w forms land in the working register
                    if (alu.writeW) begin
                        state_next.wreg = alu.value;
                    end
                    if (alu.writeMem) begin
                        // memory keeps its byte for the to-w forms: no strobe
                        state_next.mem.we = 1'b1;
                        state_next.mem.addr = instr.memAddr;
                        state_next.mem.data = alu.value;
                    end
                    // only the opcodes that name the zero flag touch it
                    if (alu.writeZero) begin
                        state_next.flags.zero = is_zero(alu.value);
                    end
                    // bcd adjust is the only user of the carry path here
                    if (alu.writeCarry) begin
                        state_next.flags.carry = alu.carry;
                    end
                    // control flow and power side effects
                    unique case (instr.op)
                        OP_JUMP_ABSOLUTE: begin
                            state_next.pc = PC_WIDTH'(instr.target);
                            // a dummy cycle follows while the new address is fetched
                            state_next.fsm = ST_JUMP_FLUSH;
                            state_next.ready = 1'b0;
                        end
                        OP_POWER_DOWN: begin
                            state_next.fsm = ST_SLEEP;
                            state_next.ready = 1'b0;
                            state_next.halt = 1'b1;
                            // clock gate drops with the halt so no further fetch starts
                            state_next.clkEn = 1'b0;
                            state_next.wdtClear = 1'b1;
                            state_next.flags.powerDown = 1'b1;
                            // this clear may still lose to a same-cycle timeout event below
                            state_next.flags.watchdogTimeout = 1'b0;
                        end
                        default: begin
                            // every other opcode, nop included, simply moves on
                            state_next.fsm = ST_RUN;
                        end
                    endcase
                end
            end
            ST_JUMP_FLUSH: begin
                // no instruction can be taken here, since ready is low
                // second and last cycle of the jump; jump lasts JUMP_CYCLES
                state_next.fsm = ST_RUN;
                state_next.ready = 1'b1;
            end
            ST_SLEEP: begin
                // pc, working register and memory simply hold; flags still take loads and timeouts; only a wake resumes fetch
                // wake is a level; the synchroniser adds two edges of latency
                if (wakeSync) begin
                    state_next.fsm = ST_RUN;
                    state_next.halt = 1'b0;
                    state_next.ready = 1'b1;
                    state_next.clkEn = 1'b1;
                end
            end
            default: begin
                // illegal gray code: recover to run
                // the unused code can only come from an upset; run is the safe choice
                state_next.halt = 1'b0;
                state_next.fsm = ST_RUN;
                state_next.ready = 1'b1;
                state_next.clkEn = 1'b1;
            end
        endcase

        // a timeout event wins over the clear done by power-down entry
        if (watchdogTimeoutEvent) begin
            state_next.flags.watchdogTimeout = 1'b1;
        end
    end

    // single state register; the only flops of the unit besides the
    // two synchronisers, and its reset values are constants only
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_reg <= '{fsm: ST_RUN, pc: PC_RESET, wreg: BYTE_ZERO, flags: '0,
                           mem: '0, wdtClear: 1'b0, clkEn: 1'b1, ready: 1'b1, halt: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register; the memory strobe and the
    // watchdog clear are single-cycle pulses, the rest are levels
    assign ready = state_reg.ready;
    assign workingRegister = state_reg.wreg;
    assign flags = state_reg.flags;
    assign programCounter = state_reg.pc;
    assign memWrite = state_reg.mem;
    assign watchdogClear = state_reg.wdtClear;
    assign systemClockEnable = state_reg.clkEn;
    assign halted = state_reg.halt;

endmodule

// ### dv/mise_exec_assertions.sv
// checker: port-level properties of the execution unit
module mise_exec_assertions #(
    parameter int PC_WIDTH = mise_pkg::PC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // issue side
    input wire mise_pkg::mise_instr_t instr,
    input wire logic ready,
    input wire logic flagLoad,
    input wire logic watchdogTimeoutEvent,
    // state and strobes
    input wire logic [mise_pkg::DATA_W-1:0] workingRegister,
    input wire mise_pkg::mise_flags_t flags,
    input wire logic [PC_WIDTH-1:0] programCounter,
    input wire mise_pkg::mise_memwr_t memWrite,
    input wire logic watchdogClear,
    input wire logic systemClockEnable,
    input wire logic halted
);
    timeunit 1ns;
    timeprecision 1ps;
    import mise_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // an instruction is taken on this edge
    wire logic tk = instr.valid && ready;
    // expected {carry, byte}; digit tests look at the original byte
    function automatic logic [8:0] bcd(input logic [7:0] w, input logic c, input logic h);
        logic [8:0] s;
        s = {1'b0, w} + {1'b0, (w[7:4] > 4'h9 || c) ? 4'h6 : 4'h0, (w[3:0] > 4'h9 || h) ? 4'h6 : 4'h0};
        return {s[8] | c, s[7:0]};
    endfunction
    // jump: dummy cycle, then issue reopens
    sequence s_jump; !ready ##1 ready; endsequence
    // sleep entry: one clear pulse, flags set
    sequence s_sleep;
        halted && !systemClockEnable && watchdogClear && flags.powerDown && !flags.watchdogTimeout ##1 !watchdogClear;
    endsequence
    property p_cpl; tk && instr.op == OP_COMPLEMENT_TO_W |=> workingRegister == ~$past(instr.memData)
        && !memWrite.we && flags.zero == ($past(instr.memData) == 8'hFF); endproperty
    property p_dec; tk && instr.op == OP_MEMORY_MINUS_ONE |=> memWrite.we && memWrite.addr == $past(instr.memAddr)
        && memWrite.data == $past(instr.memData) - 8'h01 && flags.zero == ($past(instr.memData) == 8'h01); endproperty
    property p_memory_minus_one_to_w; tk && instr.op == OP_MEMORY_MINUS_ONE_TO_W |=> !memWrite.we
        && workingRegister == $past(instr.memData) - 8'h01 && flags.zero == ($past(instr.memData) == 8'h01); endproperty
    property p_inc; tk && instr.op == OP_MEMORY_PLUS_ONE |=> memWrite.we && memWrite.addr == $past(instr.memAddr)
        && memWrite.data == $past(instr.memData) + 8'h01 && flags.zero == ($past(instr.memData) == 8'hFF); endproperty
    property p_memory_plus_one_to_w; tk && instr.op == OP_MEMORY_PLUS_ONE_TO_W |=> !memWrite.we
        && workingRegister == $past(instr.memData) + 8'h01 && flags.zero == ($past(instr.memData) == 8'hFF); endproperty
    property p_bcd; tk && instr.op == OP_BCD_ADJUST && !flagLoad |=> memWrite.we && {flags.carry, memWrite.data}
        == bcd($past(workingRegister), $past(flags.carry), $past(flags.halfCarry)) && $stable(workingRegister)
        && $stable(flags.zero) && $stable(flags.halfCarry) && $stable(flags.powerDown); endproperty
    property p_jmp; tk && instr.op == OP_JUMP_ABSOLUTE |=> programCounter == $past(instr.target) ##0 s_jump; endproperty
    property p_halt; tk && instr.op == OP_POWER_DOWN && !watchdogTimeoutEvent |=> s_sleep; endproperty
    property p_asleep; halted |-> !ready && !systemClockEnable && !memWrite.we; endproperty
    a_cpl: assert property (p_cpl) else $error("complement result wrong");
    a_dec: assert property (p_dec) else $error("memory minus one wrong");
    a_memory_minus_one_to_w: assert property (p_memory_minus_one_to_w) else $error("minus one to w wrong");
    a_inc: assert property (p_inc) else $error("memory plus one wrong");
    a_memory_plus_one_to_w: assert property (p_memory_plus_one_to_w) else $error("plus one to w wrong");
    a_bcd: assert property (p_bcd) else $error("bcd adjust wrong");
    a_jmp: assert property (p_jmp) else $error("jump wrong");
    a_halt: assert property (p_halt) else $error("power down entry wrong");
    a_asleep: assert property (p_asleep) else $error("activity while asleep");
endmodule

bind mise_exec mise_exec_assertions #(.PC_WIDTH(PC_WIDTH)) chk (.clk(clk), .rstn(rstn), .instr(instr),
    .ready(ready), .flagLoad(flagLoad), .watchdogTimeoutEvent(watchdogTimeoutEvent),
    .workingRegister(workingRegister), .flags(flags), .programCounter(programCounter), .memWrite(memWrite),
    .watchdogClear(watchdogClear), .systemClockEnable(systemClockEnable), .halted(halted));

// ### dv/mise_exec_bench.sv
// testbench: directed instruction sequences against the execution unit
module mise_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mise_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    mise_instr_t instr = '0;
    logic flagLoad = 1'b0;
    mise_flags_t flagLoadValue = '0;
    logic watchdogTimeoutEvent = 1'b0;
    logic wakePin = 1'b0;
    logic ready, watchdogClear, systemClockEnable, halted;
    logic [DATA_W-1:0] workingRegister;
    mise_flags_t flags;
    logic [PC_W-1:0] programCounter;
    mise_memwr_t memWrite;
    int fail_count = 0;
    int cmp_count = 0;
    // bcd cases: byte, carry in, half carry in, result, carry out
    logic [7:0] bw [6] = '{8'h12, 8'h1A, 8'h12, 8'hA2, 8'hAA, 8'h45};
    logic [7:0] be [6] = '{8'h12, 8'h20, 8'h18, 8'h02, 8'h10, 8'hA5};
    logic [5:0] bc = 6'b100000;
    logic [5:0] bh = 6'b000100;
    logic [5:0] bo = 6'b111000;

    mise_exec dut (.clk(clk), .rstn(rstn), .instr(instr), .ready(ready), .flagLoad(flagLoad),
        .flagLoadValue(flagLoadValue), .watchdogTimeoutEvent(watchdogTimeoutEvent), .wakePin(wakePin),
        .workingRegister(workingRegister), .flags(flags), .programCounter(programCounter), .memWrite(memWrite),
        .watchdogClear(watchdogClear), .systemClockEnable(systemClockEnable), .halted(halted));

    always #5 clk = ~clk;

    // one compare, counted
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one instruction held for a single edge; ends where results have settled
    task automatic run(input mise_op_t op, input logic [7:0] a, input logic [7:0] d, input logic [11:0] t);
        @(negedge clk);
        instr = '{1'b1, op, a, d, t};
        @(posedge clk);
        @(negedge clk);
        instr.valid = 1'b0;
    endtask
    // flags as another core instruction would leave them
    task automatic load(input mise_flags_t v);
        @(negedge clk);
        flagLoad = 1'b1;
        flagLoadValue = v;
        @(negedge clk);
        flagLoad = 1'b0;
    endtask
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        run(OP_COMPLEMENT_TO_W, 8'h10, 8'h5A, '0);
        chk("cpl", {1'b0, 8'hA5, 1'b0}, {memWrite.we, workingRegister, flags.zero});
        run(OP_COMPLEMENT_TO_W, 8'h10, 8'hFF, '0);
        chk("cpl zero", 1'b1, flags.zero);
        run(OP_MEMORY_PLUS_ONE, 8'h21, 8'hFF, '0);
        chk("inc", {1'b1, 8'h21, 8'h00, 1'b1}, {memWrite, flags.zero});
        run(OP_MEMORY_PLUS_ONE_TO_W, 8'h22, 8'h7F, '0);
        chk("memory_plus_one_to_w", {1'b0, 8'h80, 1'b0}, {memWrite.we, workingRegister, flags.zero});
        run(OP_MEMORY_MINUS_ONE, 8'h23, 8'h00, '0);
        chk("dec", {1'b1, 8'h23, 8'hFF, 1'b0}, {memWrite, flags.zero});
        run(OP_MEMORY_MINUS_ONE_TO_W, 8'h24, 8'h01, '0);
        chk("memory_minus_one_to_w", {1'b0, 8'h00, 1'b1}, {memWrite.we, workingRegister, flags.zero});
        // every correction constant, carry and half carry as causes
        for (int i = 0; i < 6; i++) begin
            run(OP_COMPLEMENT_TO_W, 8'h30, ~bw[i], '0);
            load({1'b0, bc[i], bh[i], 2'b00});
            run(OP_BCD_ADJUST, 8'h31, 8'h00, '0);
            chk("bcd mem", {1'b1, 8'h31, be[i]}, memWrite);
            chk("bcd flags", {bw[i], 1'b0, bo[i], bh[i], 2'b00}, {workingRegister, flags});
        end
        // jump then an instruction in the first open cycle
        run(OP_JUMP_ABSOLUTE, 8'h00, 8'h00, 12'h3C5);
        chk("jmp", {1'b0, 12'h3C5}, {ready, programCounter});
        run(OP_MEMORY_PLUS_ONE, 8'h25, 8'h10, '0);
        chk("after jmp", {12'h3C6, 1'b1, 8'h11}, {programCounter, memWrite.we, memWrite.data});
        @(negedge clk);
        watchdogTimeoutEvent = 1'b1;
        @(negedge clk);
        watchdogTimeoutEvent = 1'b0;
        chk("timeout", 1'b1, flags.watchdogTimeout);
        run(OP_POWER_DOWN, 8'h00, 8'h00, '0);
        chk("sleep", 7'b1001101, {halted, ready, systemClockEnable, watchdogClear, flags[1:0], flags.carry});
        @(negedge clk);
        chk("wd pulse", 1'b0, watchdogClear);
        // refused while asleep; state kept
        run(OP_MEMORY_PLUS_ONE, 8'h40, 8'h10, '0);
        chk("asleep", {1'b0, 12'h3C7, 8'h45}, {memWrite.we, programCounter, workingRegister});
        @(negedge clk);
        wakePin = 1'b1;
        repeat (5) @(negedge clk);
        wakePin = 1'b0;
        chk("wake", 3'b011, {halted, ready, systemClockEnable});
        summarize();
    end

    // hang guard, far beyond the 84 cycles used
    initial begin
        #20us;
        fail_count++;
        summarize();
    end
endmodule
